// [logic/scsm_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scsm_cfg.svh"
module scsm_top
    import scsm_pkg::*;
#(
    parameter int SOCKET_INDEX = 0,
    parameter int TIMEWAIT_CYCLES = `SCSM_TIMEWAIT_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [15:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic PEER_SYN_IN,
    input wire logic PEER_ACK_IN,
    input wire logic PEER_FIN_IN,
    input wire logic ARP_REPLY_IN,
    input wire logic TIMEOUT_IN,
    input wire logic SEND_DONE_IN,
    input wire logic [15:0] RX_WR_PTR_IN,
    output logic [2:0] LINK_ACT_OUT,
    output logic [15:0] LINK_LEN_OUT,
    output logic LINK_USE_HWADDR_OUT,
    output logic [7:0] SOCK_STATE_OUT
);
    // Refuse settings the logic cannot serve
    if (SOCKET_INDEX < 0 || SOCKET_INDEX > 3 || TIMEWAIT_CYCLES < 1 || TIMEWAIT_CYCLES > 65535) begin : g_chk
        $error("scsm_top: bad SOCKET_INDEX or TIMEWAIT_CYCLES");
    end

    localparam logic [15:0] TW_LAST = 16'(TIMEWAIT_CYCLES - 1);

    scsm_regs_t r, n;

    // Byte address to word index; low two bits must be zero
    function automatic logic [11:0] idx_of(input logic [15:0] a);
        return a[13:2];
    endfunction

    function automatic logic idx_ok(input logic [15:0] a);
        logic [11:0] i;
        i = a[13:2];
        return a[1:0] == 2'b00 && a[15:14] == 2'b00 &&
            (i == `SCSM_IDX_MODE || i == `SCSM_IDX_CMD || i == `SCSM_IDX_FLAGS ||
             i == `SCSM_IDX_STATE || i == `SCSM_IDX_TXRD || i == `SCSM_IDX_TXWR ||
             i == `SCSM_IDX_RSR || i == `SCSM_IDX_RXRD);
    endfunction

    logic wr_en;
    logic cmd_wr;
    logic [4:0] clr_f;
    logic [4:0] set_f;
    assign wr_en = PSEL_IN & PENABLE_IN & r.pready & PWRITE_IN;
    assign cmd_wr = wr_en && idx_of(PADDR_IN) == `SCSM_IDX_CMD && PADDR_IN[1:0] == 2'b00;

    // Next-state logic: link events, then commands, then bus access
    always_comb begin
        n = r;
        set_f = 5'h00;
        clr_f = 5'h00;
        n.act = ACT_NONE;
        n.pready = PSEL_IN & ~PENABLE_IN;
        n.perr = 1'b0;
        n.prdata = 32'h0000_0000;
        // New data arrival raises the receive flag
        n.rxseen = RX_WR_PTR_IN;
        if (RX_WR_PTR_IN != r.rxseen) begin
            set_f[`SCSM_F_RECV] = 1'b1;
        end
        // Send completion: read pointer catches up with the snapshot
        if (r.busy && SEND_DONE_IN) begin
            n.busy = 1'b0;
            n.txrd = r.txsnap;
            set_f[`SCSM_F_SENDOK] = 1'b1;
        end
        // Peer driven progress of the socket
        case (r.st)
            ST_LISTEN: begin
                if (PEER_SYN_IN) begin
                    n.st = ST_SYNRECV;
                    n.act = ACT_SYNACK;
                end
            end
            ST_SYNRECV, ST_SYNSENT: begin
                if (TIMEOUT_IN) begin
                    n.st = ST_CLOSED;
                    set_f[`SCSM_F_TOUT] = 1'b1;
                end else if (PEER_ACK_IN) begin
                    n.st = ST_ESTAB;
                    set_f[`SCSM_F_CON] = 1'b1;
                end
            end
            ST_ARP_TCP: begin
                if (TIMEOUT_IN) begin
                    n.st = ST_CLOSED;
                    set_f[`SCSM_F_TOUT] = 1'b1;
                end else if (ARP_REPLY_IN) begin
                    n.st = ST_SYNSENT;
                    n.act = ACT_SYN;
                end
            end
            ST_ARP_UDP, ST_ARP_RAW: begin
                // Resolution failure drops the send but keeps the socket open
                if (TIMEOUT_IN) begin
                    n.st = (r.st == ST_ARP_UDP) ? ST_UDP : ST_IPRAW;
                    n.busy = 1'b0;
                    set_f[`SCSM_F_TOUT] = 1'b1;
                end else if (ARP_REPLY_IN) begin
                    n.st = (r.st == ST_ARP_UDP) ? ST_UDP : ST_IPRAW;
                    n.act = ACT_DATA;
                end
            end
            ST_ESTAB, ST_CLOSEWAIT: begin
                if (TIMEOUT_IN) begin
                    n.st = ST_CLOSED;
                    n.busy = 1'b0;
                    set_f[`SCSM_F_TOUT] = 1'b1;
                end else if (PEER_FIN_IN && r.st == ST_ESTAB) begin
                    n.st = ST_CLOSEWAIT;
                    set_f[`SCSM_F_DISC] = 1'b1;
                end
            end
            ST_FINWAIT, ST_CLOSING, ST_LASTACK: begin
                if (TIMEOUT_IN) begin
                    n.st = ST_CLOSED;
                    set_f[`SCSM_F_TOUT] = 1'b1;
                end else if (r.st == ST_LASTACK && PEER_ACK_IN) begin
                    n.st = ST_CLOSED;
                    set_f[`SCSM_F_DISC] = 1'b1;
                end else if (r.st == ST_CLOSING && PEER_ACK_IN) begin
                    n.st = ST_TIMEWAIT;
                    n.twcnt = 16'h0000;
                end else if (r.st == ST_FINWAIT && PEER_FIN_IN) begin
                    // Our FIN unanswered yet means simultaneous close
                    n.st = PEER_ACK_IN ? ST_TIMEWAIT : ST_CLOSING;
                    n.twcnt = 16'h0000;
                end
            end
            ST_TIMEWAIT: begin
                n.twcnt = r.twcnt + 16'h0001;
                if (r.twcnt == TW_LAST) begin
                    n.st = ST_CLOSED;
                    set_f[`SCSM_F_DISC] = 1'b1;
                end
            end
            default: begin
            end
        endcase
        // Command execution; any code is consumed in one cycle
        if (r.cmd != `SCSM_RST_BYTE) begin
            n.cmd = `SCSM_RST_BYTE;
            case (r.cmd)
                `SCSM_CMD_OPEN: begin
                    n.busy = 1'b0;
                    case (r.mode[3:0])
                        `SCSM_PR_TCP: n.st = ST_INIT;
                        `SCSM_PR_UDP: n.st = ST_UDP;
                        `SCSM_PR_IPRAW: n.st = ST_IPRAW;
                        `SCSM_PR_MACRAW: if (SOCKET_INDEX == 0) n.st = ST_MACRAW;
                        `SCSM_PR_PPPOE: if (SOCKET_INDEX == 0) n.st = ST_PPPOE;
                        default: begin
                        end
                    endcase
                end
                `SCSM_CMD_LISTEN: begin
                    if (r.st == ST_INIT && r.mode[3:0] == `SCSM_PR_TCP) n.st = ST_LISTEN;
                end
                `SCSM_CMD_CONNECT: begin
                    if (r.st == ST_INIT && r.mode[3:0] == `SCSM_PR_TCP) begin
                        n.st = ST_ARP_TCP;
                        n.act = ACT_ARP;
                    end
                end
                `SCSM_CMD_TERMINATE: begin
                    if (r.st == ST_ESTAB || r.st == ST_CLOSEWAIT) begin
                        n.st = (r.st == ST_ESTAB) ? ST_FINWAIT : ST_LASTACK;
                        n.act = ACT_FIN;
                    end
                end
                `SCSM_CMD_CLOSE: begin
                    n.st = ST_CLOSED;
                    n.busy = 1'b0;
                end
                `SCSM_CMD_SEND, `SCSM_CMD_SEND_HW: begin
                    // A send while one is in flight is dropped
                    if (!r.busy && (r.st == ST_ESTAB || r.st == ST_CLOSEWAIT || r.st == ST_UDP ||
                        r.st == ST_IPRAW || r.st == ST_MACRAW || r.st == ST_PPPOE) &&
                        (r.cmd == `SCSM_CMD_SEND || r.st == ST_UDP)) begin
                        n.busy = 1'b1;
                        n.txsnap = r.txwr;
                        n.len = r.txwr - r.txrd;
                        n.usehw = (r.cmd == `SCSM_CMD_SEND_HW);
                        if (r.cmd == `SCSM_CMD_SEND && r.st == ST_UDP) begin
                            n.st = ST_ARP_UDP;
                            n.act = ACT_ARP;
                        end else if (r.st == ST_IPRAW) begin
                            n.st = ST_ARP_RAW;
                            n.act = ACT_ARP;
                        end else begin
                            n.act = ACT_DATA;
                        end
                    end
                end
                `SCSM_CMD_KEEP: begin
                    if (!r.busy && r.st == ST_ESTAB) begin
                        n.act = ACT_PROBE;
                        n.len = 16'h0001;
                        n.usehw = 1'b0;
                    end
                end
                `SCSM_CMD_RECV: begin
                    n.rxcmt = r.rxrd;
                    if (r.rxseen != r.rxrd) set_f[`SCSM_F_RECV] = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Register reads are prepared in the setup cycle
        if (PSEL_IN && !PENABLE_IN) begin
            n.perr = ~idx_ok(PADDR_IN);
            case (idx_of(PADDR_IN))
                `SCSM_IDX_MODE: n.prdata = {24'h000000, r.mode};
                `SCSM_IDX_CMD: n.prdata = {24'h000000, r.cmd};
                `SCSM_IDX_FLAGS: n.prdata = {27'h0000000, r.flags};
                `SCSM_IDX_STATE: n.prdata = {24'h000000, r.st};
                `SCSM_IDX_TXRD: n.prdata = {16'h0000, r.txrd};
                `SCSM_IDX_TXWR: n.prdata = {16'h0000, r.txwr};
                `SCSM_IDX_RSR: n.prdata = {16'h0000, r.rxseen - r.rxcmt};
                `SCSM_IDX_RXRD: n.prdata = {16'h0000, r.rxrd};
                default: n.prdata = 32'h0000_0000;
            endcase
            if (n.perr) n.prdata = 32'h0000_0000;
        end
        // Writes land at the access edge
        if (wr_en && idx_ok(PADDR_IN)) begin
            case (idx_of(PADDR_IN))
                `SCSM_IDX_MODE: n.mode = PWDATA_IN[7:0];
                `SCSM_IDX_CMD: n.cmd = PWDATA_IN[7:0];
                `SCSM_IDX_FLAGS: clr_f = PWDATA_IN[4:0];
                `SCSM_IDX_TXWR: n.txwr = PWDATA_IN[15:0];
                `SCSM_IDX_RXRD: n.rxrd = PWDATA_IN[15:0];
                default: begin
                end
            endcase
        end
        // Sticky flags: a set in the clearing cycle wins
        n.flags = (r.flags & ~clr_f) | set_f;
    end

    // State register
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign PRDATA_OUT = r.prdata;
    assign PREADY_OUT = r.pready;
    assign PSLVERR_OUT = r.perr; // Error is only ever prepared alongside ready
    assign LINK_ACT_OUT = r.act;
    assign LINK_LEN_OUT = r.len;
    assign LINK_USE_HWADDR_OUT = r.usehw;
    assign SOCK_STATE_OUT = r.st;

    // Checks
    property p_cmd_clear;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.cmd != 8'h00 && !cmd_wr) |=> (r.cmd == 8'h00);
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("command not cleared");
    property p_open_tcp;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.cmd == `SCSM_CMD_OPEN && r.mode[3:0] == `SCSM_PR_TCP) |=> (r.st == ST_INIT);
    endproperty
    a_open_tcp: assert property (p_open_tcp) else $error("open did not reach init");
    property p_listen;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.cmd == `SCSM_CMD_LISTEN && r.st == ST_INIT && r.mode[3:0] == `SCSM_PR_TCP) |=> (r.st == ST_LISTEN);
    endproperty
    a_listen: assert property (p_listen) else $error("listen not entered");
    property p_close;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.cmd == `SCSM_CMD_CLOSE) |=> (r.st == ST_CLOSED && !r.busy);
    endproperty
    a_close: assert property (p_close) else $error("close not immediate");
    property p_con_flag;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.st != ST_ESTAB ##1 r.st == ST_ESTAB) |-> r.flags[`SCSM_F_CON];
    endproperty
    a_con_flag: assert property (p_con_flag) else $error("connect flag missing");
    property p_sticky;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.flags[`SCSM_F_DISC] && !(wr_en && idx_of(PADDR_IN) == `SCSM_IDX_FLAGS && PWDATA_IN[1]))
        |=> r.flags[`SCSM_F_DISC];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
    property p_send_ok;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.busy && SEND_DONE_IN) |=> (r.flags[`SCSM_F_SENDOK] && !r.busy && r.txrd == $past(r.txsnap));
    endproperty
    a_send_ok: assert property (p_send_ok) else $error("send completion wrong");
    property p_close_wait;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.st == ST_ESTAB && PEER_FIN_IN && !TIMEOUT_IN && r.cmd == 8'h00) |=> (r.st == ST_CLOSEWAIT);
    endproperty
    a_close_wait: assert property (p_close_wait) else $error("no close-wait");
    property p_conn_tout;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.st == ST_SYNSENT && TIMEOUT_IN && r.cmd == 8'h00) |=> (r.st == ST_CLOSED && r.flags[`SCSM_F_TOUT]);
    endproperty
    a_conn_tout: assert property (p_conn_tout) else $error("connect timeout wrong");
    property p_raw_frame;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (r.cmd == `SCSM_CMD_OPEN && (r.mode[3:0] == `SCSM_PR_MACRAW || r.mode[3:0] == `SCSM_PR_PPPOE))
        |=> ((SOCKET_INDEX == 0) == (r.st == ST_MACRAW || r.st == ST_PPPOE));
    endproperty
    a_raw_frame: assert property (p_raw_frame) else $error("raw frame on other socket");
    c_estab: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) r.st == ST_SYNSENT ##1 r.st == ST_ESTAB);
    c_send: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) r.busy && SEND_DONE_IN);
    c_tw: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN) r.st == ST_TIMEWAIT ##1 r.st == ST_CLOSED);
endmodule
`default_nettype wire

// [logic/scsm_cfg.svh]
`ifndef SCSM_CFG_SVH
`define SCSM_CFG_SVH
// Register indices; byte address is four times the index
`define SCSM_IDX_MODE 12'h400
`define SCSM_IDX_CMD 12'h401
`define SCSM_IDX_FLAGS 12'h402
`define SCSM_IDX_STATE 12'h403
`define SCSM_IDX_TXRD 12'h422
`define SCSM_IDX_TXWR 12'h424
`define SCSM_IDX_RSR 12'h426
`define SCSM_IDX_RXRD 12'h428
// Command codes
`define SCSM_CMD_OPEN 8'h01
`define SCSM_CMD_LISTEN 8'h02
`define SCSM_CMD_CONNECT 8'h04
`define SCSM_CMD_TERMINATE 8'h08
`define SCSM_CMD_CLOSE 8'h10
`define SCSM_CMD_SEND 8'h20
`define SCSM_CMD_SEND_HW 8'h21
`define SCSM_CMD_KEEP 8'h22
`define SCSM_CMD_RECV 8'h40
// Protocol select codes, low nibble of the mode register
`define SCSM_PR_TCP 4'h1
`define SCSM_PR_UDP 4'h2
`define SCSM_PR_IPRAW 4'h3
`define SCSM_PR_MACRAW 4'h4
`define SCSM_PR_PPPOE 4'h5
// Event flag bit positions
`define SCSM_F_CON 0
`define SCSM_F_DISC 1
`define SCSM_F_RECV 2
`define SCSM_F_TOUT 3
`define SCSM_F_SENDOK 4
// Reset values and timing
`define SCSM_RST_BYTE 8'h00
`define SCSM_RST_PTR 16'h0000
`define SCSM_TIMEWAIT_CYC 64
`endif

// [logic/scsm_pkg.sv]
`default_nettype none
package scsm_pkg;
    // Socket state codes as shown in the state register
    typedef enum logic [7:0] {
        ST_CLOSED = 8'h00, ST_ARP_TCP = 8'h11, ST_INIT = 8'h13,
        ST_LISTEN = 8'h14, ST_SYNSENT = 8'h15, ST_SYNRECV = 8'h16,
        ST_ESTAB = 8'h17, ST_FINWAIT = 8'h18, ST_CLOSING = 8'h1a,
        ST_TIMEWAIT = 8'h1b, ST_CLOSEWAIT = 8'h1c, ST_LASTACK = 8'h1d,
        ST_ARP_UDP = 8'h21, ST_UDP = 8'h22, ST_ARP_RAW = 8'h31,
        ST_IPRAW = 8'h32, ST_MACRAW = 8'h42, ST_PPPOE = 8'h5f
    } scsm_state_t;
    // Requests to the link engine
    typedef enum logic [2:0] {
        ACT_NONE = 3'b000, ACT_ARP = 3'b001, ACT_SYN = 3'b010,
        ACT_SYNACK = 3'b011, ACT_FIN = 3'b100, ACT_DATA = 3'b101,
        ACT_PROBE = 3'b110
    } scsm_act_t;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] cmd;
        logic [4:0] flags;
        scsm_state_t st;
        logic [15:0] txwr;
        logic [15:0] txrd;
        logic [15:0] txsnap;
        logic [15:0] rxrd;
        logic [15:0] rxcmt;
        logic [15:0] rxseen;
        logic busy;
        logic [15:0] twcnt;
        scsm_act_t act;
        logic [15:0] len;
        logic usehw;
        logic pready;
        logic perr;
        logic [31:0] prdata;
    } scsm_regs_t;
endpackage
`default_nettype wire

// [verif/scsm_peer_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-side link engine and peer; answers the latest link action after a delay, except a probe to a live peer
module scsm_peer_model
    import scsm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] act_in,
    input wire logic [3:0] delay_in,
    input wire logic dead_in,
    input wire logic syn_req_in,
    input wire logic fin_req_in,
    output logic syn_out,
    output logic ack_out,
    output logic fin_out,
    output logic arp_out,
    output logic tout_out,
    output logic done_out
);
    logic [2:0] pend_r;
    logic [3:0] cnt_r;
    // One action pending at a time; a new request replaces the old one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_r <= ACT_NONE;
            cnt_r <= 4'h0;
            {syn_out, ack_out, fin_out, arp_out, tout_out, done_out} <= 6'h00;
        end else begin
            {ack_out, arp_out, tout_out, done_out} <= 4'h0;
            syn_out <= syn_req_in;
            fin_out <= fin_req_in;
            if (act_in != ACT_NONE) begin
                pend_r <= act_in;
                cnt_r <= delay_in;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else begin
                pend_r <= ACT_NONE;
                case (pend_r)
                    ACT_ARP: arp_out <= 1'b1;
                    ACT_SYN, ACT_SYNACK: {ack_out, tout_out} <= {~dead_in, dead_in}; // Silent peer lets it expire
                    ACT_FIN: {ack_out, fin_out} <= 2'b11; // Peer acks and closes its side too
                    ACT_DATA: done_out <= 1'b1;
                    ACT_PROBE: tout_out <= dead_in; // Silent peer means expiry
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scsm_cfg.svh"
module testbench;
    import scsm_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [15:0] paddr, rx_wr, len;
    logic [31:0] pwdata, prdata, rd;
    logic syn, ack, fin, arp, tout, done, use_hw, dead, syn_req, fin_req;
    logic [2:0] act;
    logic [3:0] dly;
    logic [7:0] st;
    int failures, n_compared;
    scsm_top #(.SOCKET_INDEX(0), .TIMEWAIT_CYCLES(4)) scsm_top_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PEER_SYN_IN(syn),
        .PEER_ACK_IN(ack), .PEER_FIN_IN(fin), .ARP_REPLY_IN(arp), .TIMEOUT_IN(tout),
        .SEND_DONE_IN(done), .RX_WR_PTR_IN(rx_wr), .LINK_ACT_OUT(act), .LINK_LEN_OUT(len),
        .LINK_USE_HWADDR_OUT(use_hw), .SOCK_STATE_OUT(st));
    scsm_peer_model scsm_peer_model_i (.clk_in(clk), .rst_n_in(rst_n), .act_in(act), .delay_in(dly),
        .dead_in(dead), .syn_req_in(syn_req), .fin_req_in(fin_req), .syn_out(syn), .ack_out(ack),
        .fin_out(fin), .arp_out(arp), .tout_out(tout), .done_out(done));
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Verdict and end of run
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait states are the slave's call; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] e, input string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, `SCSM_IDX_CMD, {24'h0, c});
    endtask
    // Bounded polls of the state code and the link action
    task automatic wst(input logic [7:0] e);
        for (int i = 0; i < 200 && st !== e; i++) @(posedge clk);
        chk("state", {24'h0, e}, {24'h0, st});
    endtask
    task automatic wact(input logic [2:0] e);
        for (int i = 0; i < 200 && act !== e; i++) @(posedge clk);
        chk("link action", {29'h0, e}, {29'h0, act});
    endtask
    logic [3:0] prs [5] = '{`SCSM_PR_TCP, `SCSM_PR_UDP, `SCSM_PR_IPRAW, `SCSM_PR_MACRAW, `SCSM_PR_PPPOE};
    logic [7:0] ops [5] = '{8'h13, 8'h22, 8'h32, 8'h42, 8'h5f};
    initial begin
        {rst_n, psel, penable, pwrite, dead, syn_req, fin_req} = 7'h00;
        {paddr, rx_wr, pwdata} = 64'h0;
        dly = 4'h8;
        failures = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`SCSM_IDX_CMD, 32'h0, "command reset");
        rdchk(`SCSM_IDX_FLAGS, 32'h0, "flags reset");
        apb(1'b1, `SCSM_IDX_STATE, 32'h55);
        rdchk(`SCSM_IDX_STATE, 32'h0, "state read-only");
        apb(1'b0, 12'h7ff, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        // Every protocol through open and close
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `SCSM_IDX_MODE, {28'h0, prs[i]});
            cmd(`SCSM_CMD_OPEN);
            rdchk(`SCSM_IDX_CMD, 32'h0, "command cleared");
            wst(ops[i]);
            cmd(`SCSM_CMD_CLOSE);
            wst(8'h00);
        end
        cmd(8'h7f);
        rdchk(`SCSM_IDX_CMD, 32'h0, "bad command cleared");
        apb(1'b1, `SCSM_IDX_MODE, {28'h0, `SCSM_PR_UDP});
        cmd(`SCSM_CMD_OPEN);
        cmd(`SCSM_CMD_LISTEN);
        rdchk(`SCSM_IDX_STATE, 32'h22, "listen refused");
        cmd(`SCSM_CMD_SEND_HW);
        wact(ACT_DATA);
        chk("preset address", 32'h1, {31'h0, use_hw});
        // Let the datagram finish, then a plain send resolves the address first
        repeat (12) @(posedge clk);
        rdchk(`SCSM_IDX_FLAGS, 32'h10, "datagram send done");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'h10);
        cmd(`SCSM_CMD_SEND);
        wst(8'h21);
        wst(8'h22);
        // Active open, then data both ways
        apb(1'b1, `SCSM_IDX_MODE, {28'h0, `SCSM_PR_TCP});
        cmd(`SCSM_CMD_OPEN);
        apb(1'b1, `SCSM_IDX_FLAGS, 32'hff);
        cmd(`SCSM_CMD_CONNECT);
        wst(8'h11);
        wst(8'h15);
        wst(8'h17);
        rdchk(`SCSM_IDX_FLAGS, 32'h01, "connect flag");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'h01);
        rdchk(`SCSM_IDX_FLAGS, 32'h00, "flag cleared");
        dly <= 4'h0;
        apb(1'b1, `SCSM_IDX_TXWR, 32'h10);
        cmd(`SCSM_CMD_SEND);
        wact(ACT_DATA);
        chk("send length", 32'h10, {16'h0, len});
        chk("no preset address", 32'h0, {31'h0, use_hw});
        repeat (8) @(posedge clk);
        rdchk(`SCSM_IDX_FLAGS, 32'h10, "send done flag");
        rdchk(`SCSM_IDX_TXRD, 32'h10, "tx read pointer");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'h10);
        rx_wr <= 16'h0020;
        repeat (4) @(posedge clk);
        rdchk(`SCSM_IDX_FLAGS, 32'h04, "receive flag");
        rdchk(`SCSM_IDX_RSR, 32'h20, "received size");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'h04);
        apb(1'b1, `SCSM_IDX_RXRD, 32'h10);
        cmd(`SCSM_CMD_RECV);
        rdchk(`SCSM_IDX_RSR, 32'h10, "size after receive");
        rdchk(`SCSM_IDX_FLAGS, 32'h04, "data remains flag");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'h04);
        // Probe to a dead peer expires the connection
        dly <= 4'h8;
        dead <= 1'b1;
        cmd(`SCSM_CMD_KEEP);
        wact(ACT_PROBE);
        wst(8'h00);
        rdchk(`SCSM_IDX_FLAGS, 32'h08, "timeout flag");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'hff);
        // Connect to a silent peer times out
        cmd(`SCSM_CMD_OPEN);
        cmd(`SCSM_CMD_CONNECT);
        wst(8'h15);
        wst(8'h00);
        rdchk(`SCSM_IDX_FLAGS, 32'h08, "connect timeout flag");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'hff);
        dead <= 1'b0;
        // Passive open, peer closes first, then our side ends
        cmd(`SCSM_CMD_OPEN);
        cmd(`SCSM_CMD_LISTEN);
        wst(8'h14);
        syn_req <= 1'b1;
        @(posedge clk);
        syn_req <= 1'b0;
        wst(8'h16);
        wst(8'h17);
        apb(1'b1, `SCSM_IDX_FLAGS, 32'hff);
        fin_req <= 1'b1;
        @(posedge clk);
        fin_req <= 1'b0;
        wst(8'h1c);
        rdchk(`SCSM_IDX_FLAGS, 32'h02, "peer close flag");
        apb(1'b1, `SCSM_IDX_FLAGS, 32'h02);
        cmd(`SCSM_CMD_TERMINATE);
        wst(8'h1d);
        wst(8'h00);
        rdchk(`SCSM_IDX_FLAGS, 32'h02, "teardown flag");
        // Active open, our side closes first through time-wait
        apb(1'b1, `SCSM_IDX_FLAGS, 32'hff);
        cmd(`SCSM_CMD_OPEN);
        cmd(`SCSM_CMD_CONNECT);
        wst(8'h17);
        apb(1'b1, `SCSM_IDX_FLAGS, 32'hff);
        cmd(`SCSM_CMD_TERMINATE);
        wst(8'h18);
        wst(8'h1b);
        wst(8'h00);
        rdchk(`SCSM_IDX_FLAGS, 32'h02, "time-wait end flag");
        complete_run();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
